// ### hw/fscp_pkg.sv
// Constants and types for the flash status and protection block
// Contract
// RULE1: Suspend opcode sets the read-only suspend flag.
// RULE2: Resume opcode or power cycle clears suspend.
// RULE3: Lock bits reset zero, set once, never clear.
// RULE4: Locked security area refuses program and erase.
// RULE5: Quad enable turns protect/hold pins into data.
// RULE6: Four-wire mode entry ignored without quad enable.
// RULE7: Four-wire mode keeps quad enable set.
// RULE8: Drive field gives 100/75/50/25 percent strength.
// RULE9: Select bit picks hold or reset pin function.
// RULE10: Hold and reset work only without quad enable.
// RULE11: Single-rate fast/dual/quad output use eight dummies.
// RULE12: Dual-I/O and word quad-I/O use four or eight.
// RULE13: Quad-I/O read dummies are 6, 4, 8, 10.
// RULE14: Double-rate reads use their own dummy tables.
// RULE15: Reserved bits ignore writes and read zero.
// RULE16: Protect 000 protects none, 111 protects all.
// RULE17: Block mode, top: upper fractions of array.
// RULE18: Block mode, bottom: lower fractions of array.
// RULE19: Sector mode, top: top 4KB to 32KB.
// RULE20: Sector mode, bottom: bottom 4KB to 32KB.
// RULE21: Overlapping program or erase ignored entirely.
// RULE22: Complement bit inverts the protected set.
// RULE23: Protect bits at S4..S2, default zero.
// RULE24: Whole request span checked before operation.
`default_nettype none

package fscp_pkg;

    // ----------------------------------------
    // Instruction codes
    // ----------------------------------------
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7A;
    localparam logic [7:0] OP_ENTER_4W = 8'h38;
    localparam logic [7:0] OP_EXIT_4W = 8'hFF;
    localparam logic [7:0] OP_WR_STATUS = 8'hE1;
    localparam logic [7:0] OP_WR_CONFIG = 8'hE3;

    // ----------------------------------------
    // Status word fields
    // ----------------------------------------
    localparam int SUS_POS = 15;
    localparam int CMP_POS = 14;
    localparam int LOCK_LSB = 11;
    localparam int QE_POS = 9;
    localparam int SEC_POS = 6;
    localparam int TB_POS = 5;
    localparam int BP_LSB = 2;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] STATUS_WR_MASK = 16'h7A7C;
    localparam logic [15:0] LOCK_MASK = 16'h3800;

    // ----------------------------------------
    // Config byte fields
    // ----------------------------------------
    localparam int DC_LSB = 0;
    localparam int DRV_LSB = 5;
    localparam int HR_POS = 7;
    localparam logic [7:0] CONFIG_RESET = 8'h20;
    localparam logic [7:0] CONFIG_WR_MASK = 8'hE3;

    // ----------------------------------------
    // Array geometry
    // ----------------------------------------
    localparam int ADDR_W = 24;
    localparam int BLOCK_BASE_SHIFT = 17;
    localparam int SECTOR_BASE_SHIFT = 11;
    localparam int SECTOR_MAX_SHIFT = 15;

    // ----------------------------------------
    // Drive strength in percent
    // ----------------------------------------
    localparam logic [6:0] DRV_PCT_00 = 7'h64;
    localparam logic [6:0] DRV_PCT_01 = 7'h4B;
    localparam logic [6:0] DRV_PCT_10 = 7'h32;
    localparam logic [6:0] DRV_PCT_11 = 7'h19;

    // ----------------------------------------
    // Dummy tables, nibble n is code n
    // ----------------------------------------
    localparam logic [15:0] DC_TAB_STR_FIXED = 16'h8888;
    localparam logic [15:0] DC_TAB_STR_DIO = 16'h8484;
    localparam logic [15:0] DC_TAB_STR_QIO = 16'hA846;
    localparam logic [15:0] DC_TAB_DTR_FAST = 16'hA846;
    localparam logic [15:0] DC_TAB_DTR_QIO = 16'hA648;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] code;
        logic [15:0] data;
    } fscp_cmd_t;

    typedef struct packed {
        logic [ADDR_W-1:0] start_addr;
        logic [ADDR_W-1:0] end_addr;
        logic security;
        logic [1:0] area;
    } fscp_req_t;

    typedef struct packed {
        logic none;
        logic all;
        logic inv;
        logic [ADDR_W-1:0] lo;
        logic [ADDR_W-1:0] hi;
    } fscp_prot_t;

    typedef struct packed {
        logic [3:0] str_fixed;
        logic [3:0] str_dual_io;
        logic [3:0] str_quad_io;
        logic [3:0] dtr_fast;
        logic [3:0] dtr_quad_io;
    } fscp_dummy_t;

    typedef struct packed {
        logic wp_asserted;
        logic hold_asserted;
        logic reset_asserted;
        logic io23_data;
    } fscp_pins_t;

    typedef enum logic [1:0] {
        MODE_SPI = 2'b01,
        MODE_FOUR = 2'b10
    } fscp_mode_t;

endpackage

`default_nettype wire

// ### hw/fscp_status_protect.sv
// Status/config bits and array write-protection decoder
`default_nettype none

module fscp_status_protect (
    input wire logic clock_in, // Core clock
    input wire logic rst_n_in, // Power-on reset
    input wire logic link_clk_in, // Serial clock
    input wire logic cmd_valid_in, // Executed command
    input wire fscp_pkg::fscp_cmd_t cmd_in, // Code and data
    input wire logic wp_pin_n_in, // Protect pin
    input wire logic hold_reset_pin_n_in, // Hold/reset pin
    input wire logic req_valid_in, // Array request
    input wire fscp_pkg::fscp_req_t req_in, // Request span
    output logic req_grant_out, // Request allowed
    output logic req_reject_out, // Request ignored
    output logic [15:0] status_word_out, // Status bits
    output logic [7:0] config_byte_out, // Config byte
    output logic four_wire_mode_out, // Four-wire mode
    output logic link_quad_enable_out, // Qe, link side
    output logic link_four_wire_out, // Mode, link side
    output fscp_pkg::fscp_pins_t pins_out, // Pin roles
    output logic [6:0] drive_pct_out, // Drive percent
    output fscp_pkg::fscp_dummy_t dummy_out // Dummy counts
);
    import fscp_pkg::*;

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------

    // Pick one nibble of a dummy table
    function automatic logic [3:0] dc_pick(
        input logic [15:0] tab,
        input logic [1:0] code
    );
        return tab[{code, 2'b00} +: 4];
    endfunction

    // Decode protect bits into a range
    function automatic fscp_prot_t prot_decode(
        input logic sec,
        input logic tb,
        input logic [2:0] bp,
        input logic cmp
    );
        fscp_prot_t p;
        logic [24:0] size;
        int sh;
        p = '0;
        size = '0;
        sh = 0;
        if (bp == 3'b000)
        begin
            p.none = 1'b1; // [RULE16]
        end
        else if (bp == 3'b111)
        begin
            p.all = 1'b1; // [RULE16]
        end
        else
        begin
            if (!sec)
            begin
                // 1/64 up to 1/2 in blocks
                sh = BLOCK_BASE_SHIFT + int'(bp);
            end
            else if (bp[2])
            begin
                // 10x and 110 cap at 32KB
                sh = SECTOR_MAX_SHIFT; // [RULE19] [RULE20]
            end
            else
            begin
                sh = SECTOR_BASE_SHIFT + int'(bp);
            end
            size = 25'h0000001 << sh;
            if (tb)
            begin
                // Bottom: from zero upward
                p.lo = '0; // [RULE18] [RULE20]
                p.hi = 24'(size - 25'h0000001);
            end
            else
            begin
                // Top: ending at the last byte
                p.lo = 24'(25'h1000000 - size); // [RULE17]
                p.hi = '1; // [RULE19]
            end
        end
        if (cmp)
        begin
            // Complement swaps none and all
            p = '{none: p.all, all: p.none, inv: 1'b1,
                lo: p.lo, hi: p.hi}; // [RULE22]
        end
        return p;
    endfunction

    // Any byte of the span protected?
    function automatic logic span_hits(
        input fscp_prot_t p,
        input logic [ADDR_W-1:0] s,
        input logic [ADDR_W-1:0] e
    );
        logic hit;
        hit = 1'b0;
        if (p.none)
        begin
            hit = 1'b0;
        end
        else if (p.all)
        begin
            hit = 1'b1;
        end
        else if (p.inv)
        begin
            // Protected lies outside lo..hi
            hit = (s < p.lo) || (e > p.hi); // [RULE22]
        end
        else
        begin
            hit = (s <= p.hi) && (e >= p.lo); // [RULE24]
        end
        return hit;
    endfunction

    // ----------------------------------------
    // Link domain: reset and command capture
    // ----------------------------------------

    logic link_rst_meta_reg; // Reset sync stage 1
    logic link_rst_n_reg; // Reset sync stage 2
    logic cmd_toggle_reg; // Flips per command
    fscp_cmd_t cmd_hold_reg; // Command held stable

    // Reset taken into the serial clock domain
    always_ff @(posedge link_clk_in)
    begin
        link_rst_meta_reg <= rst_n_in;
        link_rst_n_reg <= link_rst_meta_reg;
    end

    // Hold the word; the toggle tells the core
    always_ff @(posedge link_clk_in)
    begin
        if (!link_rst_n_reg)
        begin
            cmd_toggle_reg <= 1'b0;
            cmd_hold_reg <= '0;
        end
        else if (cmd_valid_in)
        begin
            cmd_toggle_reg <= ~cmd_toggle_reg;
            cmd_hold_reg <= cmd_in;
        end
    end

    // ----------------------------------------
    // Core domain: crossings and pin sync
    // ----------------------------------------

    logic tog_meta_reg; // Toggle sync stage 1
    logic tog_sync_reg; // Toggle sync stage 2
    logic tog_seen_reg; // Last toggle taken
    logic cmd_strobe; // One pulse per command
    logic [1:0] wp_sync_reg; // Protect pin sync
    logic [1:0] hr_sync_reg; // Hold/reset pin sync

    // Toggle crossing; the word is stable by now
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            tog_meta_reg <= 1'b0;
            tog_sync_reg <= 1'b0;
            tog_seen_reg <= 1'b0;
        end
        else
        begin
            tog_meta_reg <= cmd_toggle_reg;
            tog_sync_reg <= tog_meta_reg;
            tog_seen_reg <= tog_sync_reg;
        end
    end

    assign cmd_strobe = tog_sync_reg ^ tog_seen_reg;

    // Pins pass two flops before use
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            wp_sync_reg <= 2'b11;
            hr_sync_reg <= 2'b11;
        end
        else
        begin
            wp_sync_reg <= {wp_sync_reg[0], wp_pin_n_in};
            hr_sync_reg <= {hr_sync_reg[0],
                hold_reset_pin_n_in};
        end
    end

    // ----------------------------------------
    // Command decode
    // ----------------------------------------

    logic is_suspend; // Suspend executed
    logic is_resume; // Resume executed
    logic is_enter; // Enter four-wire mode
    logic is_exit; // Leave four-wire mode
    logic is_wr_status; // Status word write
    logic is_wr_config; // Config byte write

    always_comb
    begin
        is_suspend = cmd_strobe && (cmd_hold_reg.code == OP_SUSPEND);
        is_resume = cmd_strobe && (cmd_hold_reg.code == OP_RESUME);
        is_enter = cmd_strobe && (cmd_hold_reg.code == OP_ENTER_4W);
        is_exit = cmd_strobe && (cmd_hold_reg.code == OP_EXIT_4W);
        is_wr_status = cmd_strobe && (cmd_hold_reg.code == OP_WR_STATUS);
        is_wr_config = cmd_strobe && (cmd_hold_reg.code == OP_WR_CONFIG);
    end

    // ----------------------------------------
    // Instruction mode state
    // ----------------------------------------

    fscp_mode_t mode_reg; // Current mode
    fscp_mode_t mode_next; // Next mode
    logic [15:0] status_reg; // Status word
    logic [15:0] status_next; // Its next value

    // Entry needs quad enable already set
    always_comb
    begin
        mode_next = mode_reg;
        case (mode_reg)
            MODE_SPI:
            begin
                if (is_enter && status_reg[QE_POS])
                begin
                    mode_next = MODE_FOUR; // [RULE6]
                end
            end
            MODE_FOUR:
            begin
                if (is_exit)
                begin
                    mode_next = MODE_SPI;
                end
            end
            default:
            begin
                mode_next = MODE_SPI;
            end
        endcase
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            mode_reg <= MODE_SPI;
        end
        else
        begin
            mode_reg <= mode_next;
        end
    end

    // ----------------------------------------
    // Status word
    // ----------------------------------------

    // Writable bits only; locks are sticky
    always_comb
    begin
        status_next = status_reg;
        if (is_wr_status)
        begin
            // Reserved and read-only bits kept
            status_next = (status_reg & ~STATUS_WR_MASK)
                | (cmd_hold_reg.data
                & STATUS_WR_MASK); // [RULE15] [RULE23]
            // Lock bits may only go to one
            status_next = status_next
                | (status_reg & LOCK_MASK); // [RULE3]
            if (mode_reg == MODE_FOUR)
            begin
                // Cannot drop quad enable here
                status_next[QE_POS] = 1'b1; // [RULE7]
            end
        end
        if (is_resume)
        begin
            status_next[SUS_POS] = 1'b0; // [RULE2]
        end
        if (is_suspend)
        begin
            status_next[SUS_POS] = 1'b1; // [RULE1]
        end
    end

    // Power cycle returns every bit to default
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            status_reg <= STATUS_RESET; // [RULE2]
        end
        else
        begin
            status_reg <= status_next;
        end
    end

    // ----------------------------------------
    // Config byte
    // ----------------------------------------

    logic [7:0] config_reg; // Drive, select, dummy

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            config_reg <= CONFIG_RESET; // [RULE8]
        end
        else if (is_wr_config)
        begin
            // Gap bits stay zero
            config_reg <= cmd_hold_reg.data[7:0]
                & CONFIG_WR_MASK; // [RULE15]
        end
    end

    // ----------------------------------------
    // Pin roles and read settings
    // ----------------------------------------

    logic qe; // Quad enable now
    logic [1:0] dc; // Dummy cycle code

    assign qe = status_reg[QE_POS];
    assign dc = config_reg[DC_LSB +: 2];

    // Registered so outputs come from flops
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            pins_out <= '0;
            drive_pct_out <= DRV_PCT_01;
            dummy_out <= '0;
        end
        else
        begin
            // Quad enable turns pins into data
            pins_out.io23_data <= qe; // [RULE5]
            pins_out.wp_asserted <= !qe
                && !wp_sync_reg[1]; // [RULE5]
            pins_out.hold_asserted <= !qe
                && !config_reg[HR_POS]
                && !hr_sync_reg[1]; // [RULE9] [RULE10]
            pins_out.reset_asserted <= !qe
                && config_reg[HR_POS]
                && !hr_sync_reg[1]; // [RULE9] [RULE10]
            case (config_reg[DRV_LSB +: 2])
                2'b00: drive_pct_out <= DRV_PCT_00; // [RULE8]
                2'b01: drive_pct_out <= DRV_PCT_01;
                2'b10: drive_pct_out <= DRV_PCT_10;
                default: drive_pct_out <= DRV_PCT_11;
            endcase
            dummy_out.str_fixed <= dc_pick(DC_TAB_STR_FIXED, dc); // [RULE11]
            dummy_out.str_dual_io <= dc_pick(DC_TAB_STR_DIO, dc); // [RULE12]
            dummy_out.str_quad_io <= dc_pick(DC_TAB_STR_QIO, dc); // [RULE13]
            dummy_out.dtr_fast <= dc_pick(DC_TAB_DTR_FAST, dc); // [RULE14]
            dummy_out.dtr_quad_io <= dc_pick(DC_TAB_DTR_QIO, dc); // [RULE14]
        end
    end

    assign status_word_out = status_reg;
    assign config_byte_out = config_reg;
    assign four_wire_mode_out = (mode_reg == MODE_FOUR);

    // ----------------------------------------
    // Levels back to the link domain
    // ----------------------------------------

    logic [1:0] qe_link_reg; // Quad enable sync
    logic [1:0] mode_link_reg; // Mode sync

    // Both are slow levels; two flops each
    always_ff @(posedge link_clk_in)
    begin
        if (!link_rst_n_reg)
        begin
            qe_link_reg <= 2'b00;
            mode_link_reg <= 2'b00;
        end
        else
        begin
            qe_link_reg <= {qe_link_reg[0], qe};
            // One flop bit, not a decode that could glitch
            mode_link_reg <= {mode_link_reg[0], mode_reg[1]};
        end
    end

    assign link_quad_enable_out = qe_link_reg[1];
    assign link_four_wire_out = mode_link_reg[1];

    // ----------------------------------------
    // Program and erase gate
    // ----------------------------------------

    fscp_prot_t prot; // Decoded protected set
    logic lock_hit; // Security area locked
    logic span_bad; // Reversed span
    logic refuse; // Request must be ignored

    // Whole span checked before any array work
    always_comb
    begin
        prot = prot_decode(status_reg[SEC_POS],
            status_reg[TB_POS],
            status_reg[BP_LSB +: 3],
            status_reg[CMP_POS]);
        // Area 1..3 maps onto lock bits; 0 is none
        lock_hit = req_in.security
            && (req_in.area != 2'b00)
            && status_reg[LOCK_LSB + int'(req_in.area)
            - 1]; // [RULE4]
        span_bad = req_in.end_addr < req_in.start_addr;
        if (req_in.security)
        begin
            refuse = lock_hit; // [RULE4]
        end
        else
        begin
            // Any overlap drops the whole request
            refuse = span_bad || span_hits(prot,
                req_in.start_addr,
                req_in.end_addr); // [RULE21] [RULE24]
        end
    end

    // One-cycle answer after the request
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            req_grant_out <= 1'b0;
            req_reject_out <= 1'b0;
        end
        else
        begin
            req_grant_out <= req_valid_in && !refuse;
            req_reject_out <= req_valid_in && refuse;
        end
    end

endmodule

`default_nettype wire

// ### tb/fscp_status_monitor.sv
// Port-level checks for the status and protection block
`default_nettype none

module fscp_status_monitor (
    input wire logic clock_in, // Core clock
    input wire logic rst_n_in, // Reset
    input wire logic req_valid_in, // Request
    input wire logic req_grant_out, // Allowed
    input wire logic req_reject_out, // Ignored
    input wire logic [15:0] status_word_out, // Status
    input wire logic [7:0] config_byte_out, // Config
    input wire logic four_wire_mode_out, // Mode
    input wire fscp_pkg::fscp_pins_t pins_out, // Pin roles
    input wire logic [6:0] drive_pct_out, // Drive
    input wire fscp_pkg::fscp_dummy_t dummy_out // Dummies
);
    import fscp_pkg::*;

    // ----------------------------------------
    // Expected tables and settle windows
    // ----------------------------------------
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);

    // Dummy nibbles per code, in port order
    function automatic logic [19:0] dummy_of(input logic [1:0] c);
        logic [19:0] t [4] = '{20'h84668, 20'h88444, 20'h84886, 20'h88AAA};
        return t[c];
    endfunction

    // Outputs are registered, so only judge after a quiet spell
    sequence cfg_settled;
        ($stable(config_byte_out) && $past(rst_n_in, 2)) [*3];
    endsequence
    sequence pins_settled;
        ($stable({status_word_out[9], config_byte_out[7]})
            && $past(rst_n_in, 2)) [*5];
    endsequence

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    req_answer_a: assert property (
        req_valid_in |=> (req_grant_out ^ req_reject_out))
        else $error("request not answered by one verdict");
    answer_cause_a: assert property (
        (req_grant_out || req_reject_out) |-> $past(req_valid_in))
        else $error("verdict without a request");
    lock_sticky_a: assert property (
        ($past(status_word_out[13:11]) & ~status_word_out[13:11]) == 3'h0)
        else $error("lock bit cleared");
    reserved_zero_a: assert property (
        {status_word_out[10], status_word_out[8:7], status_word_out[1:0],
         config_byte_out[4:2]} == 8'h00)
        else $error("reserved bit set");
    drive_map_a: assert property (
        cfg_settled |-> drive_pct_out == 7'(100 - 25 * config_byte_out[6:5]))
        else $error("drive strength mismatch");
    dummy_map_a: assert property (
        cfg_settled |-> dummy_out == dummy_of(config_byte_out[1:0]))
        else $error("dummy count mismatch");
    quad_pins_a: assert property (
        pins_settled ##0 status_word_out[9] |-> pins_out == 4'b0001)
        else $error("pin controls active with quad enable");
    hold_select_a: assert property (
        pins_settled ##0 !status_word_out[9] |-> !(config_byte_out[7]
            ? pins_out.hold_asserted : pins_out.reset_asserted))
        else $error("wrong hold or reset role");
    mode_qe_a: assert property (
        four_wire_mode_out |-> status_word_out[9])
        else $error("quad enable low in four-wire mode");
    mode_entry_a: assert property (
        $rose(four_wire_mode_out) |-> $past(status_word_out[9]))
        else $error("four-wire entry without quad enable");
endmodule

`default_nettype wire

// ### tb/fscp_host_model.sv
// Host controller model clocking commands into the link side
`default_nettype none

module fscp_host_model (
    output logic link_clk_out, // Serial clock, idle low
    output logic cmd_valid_out, // Command strobe
    output var fscp_pkg::fscp_cmd_t cmd_out // Code and data
);
    timeunit 1ns;
    timeprecision 1ps;
    import fscp_pkg::*;

    // Clock only runs while idle or send ticks it; it rests low otherwise
    initial
    begin
        link_clk_out = 1'b0;
        cmd_valid_out = 1'b0;
        cmd_out = '0;
    end

    // One 160 ns serial clock period
    task automatic tick();
        #80 link_clk_out = 1'b1;
        #80 link_clk_out = 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) tick();
    endtask

    // Odd offset keeps the link unrelated to the core clock
    task automatic send(input logic [7:0] code, input logic [15:0] data);
        #7;
        cmd_out = {code, data};
        cmd_valid_out = 1'b1;
        tick();
        cmd_valid_out = 1'b0;
        cmd_out = ~cmd_out; // Released bus shows no stale value
        repeat (5) tick(); // Spacing plus time for the link flags
    endtask
endmodule

`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the status and protection block
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fscp_pkg::*;

    logic clock_in, rst_n_in, link_clk, cmd_valid, wp_n, hr_n, req_valid;
    logic grant, reject, fw, lqe, lfw;
    logic [15:0] status;
    logic [7:0] cfg;
    logic [6:0] pct;
    fscp_cmd_t cmd;
    fscp_req_t req;
    fscp_pins_t pins;
    fscp_dummy_t dum;
    int err_count = 0;
    int cmp_count = 0;
    logic [19:0] dum_tab [4] = '{20'h84668, 20'h88444, 20'h84886, 20'h88AAA};

    fscp_status_protect dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .link_clk_in(link_clk), .cmd_valid_in(cmd_valid), .cmd_in(cmd),
        .wp_pin_n_in(wp_n), .hold_reset_pin_n_in(hr_n),
        .req_valid_in(req_valid), .req_in(req), .req_grant_out(grant),
        .req_reject_out(reject), .status_word_out(status),
        .config_byte_out(cfg), .four_wire_mode_out(fw),
        .link_quad_enable_out(lqe), .link_four_wire_out(lfw),
        .pins_out(pins), .drive_pct_out(pct), .dummy_out(dum));
    fscp_host_model host_u (.link_clk_out(link_clk),
        .cmd_valid_out(cmd_valid), .cmd_out(cmd));

    // ----------------------------------------
    // Clock, verdict and access tasks
    // ----------------------------------------
    initial
    begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end

    task automatic wrap_up();
        if (err_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Command, then let the core copy settle
    task automatic cmd_do(input logic [7:0] c, input logic [15:0] d);
        host_u.send(c, d);
        repeat (4) @(negedge clock_in);
    endtask

    // Two requests back to back under one status setting
    task automatic pair(input logic [15:0] st, input logic [23:0] s0, e0,
        input logic ok0, input logic [23:0] s1, e1, input logic ok1,
        input logic [2:0] a0, a1);
        cmd_do(OP_WR_STATUS, st);
        req_valid = 1'b1;
        req = {s0, e0, a0};
        @(negedge clock_in);
        req = {s1, e1, a1};
        check({grant, reject}, {ok0, !ok0});
        @(negedge clock_in);
        req_valid = 1'b0;
        req = ~req;
        check({grant, reject}, {ok1, !ok1});
    endtask

    task automatic pb(input logic [15:0] st, input logic [23:0] x0,
        input logic ok0, input logic [23:0] x1, input logic ok1);
        pair(st, x0, x0, ok0, x1, x1, ok1, 3'h0, 3'h0);
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        rst_n_in = 1'b0;
        req_valid = 1'b0;
        req = '0;
        wp_n = 1'b1;
        hr_n = 1'b1;
        fork
            host_u.idle(4);
            repeat (12) @(negedge clock_in);
        join
        @(negedge clock_in);
        rst_n_in = 1'b1;
        @(negedge clock_in);
        check(status, STATUS_RESET);
        check(cfg, 8'h20);
        check(pct, 7'h4B);
        check(dum, dum_tab[0]);
        host_u.idle(3);
        cmd_do(OP_ENTER_4W, 16'h0000);
        check(fw, 1'b0);
        wp_n = 1'b0;
        hr_n = 1'b0;
        repeat (5) @(negedge clock_in);
        check(pins, 4'b1100);
        cmd_do(OP_WR_CONFIG, 16'h00A0);
        check(pins, 4'b1010);
        cmd_do(OP_WR_STATUS, 16'h0200);
        check(pins, 4'b0001);
        cmd_do(OP_ENTER_4W, 16'h0000);
        check({fw, lfw, lqe}, 3'b111);
        cmd_do(OP_WR_STATUS, 16'h0000);
        check(status, 16'h0200);
        wp_n = 1'b1;
        hr_n = 1'b1;
        cmd_do(OP_EXIT_4W, 16'h0000);
        cmd_do(OP_WR_STATUS, 16'h0000);
        check({fw, lfw, lqe, status}, 19'h0);
        cmd_do(OP_SUSPEND, 16'h0000);
        cmd_do(OP_WR_STATUS, 16'h0000);
        check(status, 16'h8000);
        cmd_do(OP_RESUME, 16'h0000);
        check(status, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            cmd_do(OP_WR_CONFIG, 16'(i * 33));
            check(pct, 100 - 25 * i);
            check(dum, dum_tab[i]);
        end
        cmd_do(OP_WR_CONFIG, 16'h00FF);
        check(cfg, 8'hE3);
        cmd_do(OP_WR_STATUS, 16'h0800);
        cmd_do(OP_WR_STATUS, 16'h0000);
        check(status, 16'h0800);
        pair(16'h0, 0, 24'h3FF, 1, 0, 24'h3FF, 0, 3'h6, 3'h5);
        cmd_do(OP_WR_STATUS, 16'hFFFF);
        check(status, 16'h7A7C);
        pair(16'h0, 0, 24'hFFFFFF, 1, 24'hFFFFFF, 0, 0, 3'h0, 3'h0);
        pb(16'h007C, 24'h0, 0, 24'h123456, 0);
        pb(16'h0004, 24'hFBFFFF, 1, 24'hFC0000, 0);
        pb(16'h0018, 24'h7FFFFF, 1, 24'h800000, 0);
        pb(16'h0024, 24'h03FFFF, 0, 24'h040000, 1);
        pb(16'h004C, 24'hFFBFFF, 1, 24'hFFC000, 0);
        pb(16'h0054, 24'hFF7FFF, 1, 24'hFF8000, 0);
        pb(16'h0064, 24'h000FFF, 0, 24'h001000, 1);
        pb(16'h0078, 24'h007FFF, 0, 24'h008000, 1);
        pair(16'h0004, 24'hFB0000, 24'hFC0000, 0, 24'hFB0000, 24'hFBFFFF, 1,
            3'h0, 3'h0);
        pb(16'h4004, 24'hFC0000, 1, 24'hFBFFFF, 0);
        wrap_up();
    end

    // Hang guard, far past a normal run
    initial
    begin
        #300us;
        err_count++;
        wrap_up();
    end
endmodule

bind fscp_status_protect fscp_status_monitor mon_u (.*);

`default_nettype wire
